// file: rtl/ppdc_consts.vh
`ifndef PPDC_CONSTS_VH
`define PPDC_CONSTS_VH
`define PPDC_CLK_MHZ        40
`define PPDC_RECOVER_US     1
// Recovery count is 1 us of 40 MHz clock cycles, sized to the counter.
`define PPDC_RECOVER_CYC    6'h28
`define PPDC_CNT_W          6
`define PPDC_CNT_ONE        6'h01
`define PPDC_CNT_ZERO       6'h00
`define PPDC_ST_RUN         2'h0
`define PPDC_ST_DOWN        2'h1
`define PPDC_ST_RECOVER     2'h2
`endif

// file: rtl/ppdc_power_down.v
`timescale 1ns/100ps
`include "ppdc_consts.vh"

module ppdc_power_down #(
    parameter DATA_W = 8
) (
    input  wire              i_clk,
    input  wire              i_srst,
    input  wire              i_pd_en_a,
    input  wire              i_pd_en_b,
    input  wire              i_power_down_pin_a,
    input  wire              i_power_down_pin_b,
    input  wire [DATA_W-1:0] i_pin_in,
    input  wire [DATA_W-1:0] i_out_data,
    input  wire [DATA_W-1:0] i_out_oe,
    output reg  [DATA_W-1:0] o_pin_in_held,
    output reg  [DATA_W-1:0] o_pin_out,
    output reg  [DATA_W-1:0] o_pin_oe,
    output reg               o_gp_a,
    output reg               o_gp_b,
    output reg               o_logic_run,
    output reg               o_power_down,
    output reg               o_valid
);

    localparam [1:0]             ST_RUN      = `PPDC_ST_RUN;
    localparam [1:0]             ST_DOWN     = `PPDC_ST_DOWN;
    localparam [1:0]             ST_RECOVER  = `PPDC_ST_RECOVER;
    localparam [`PPDC_CNT_W-1:0] RECOVER_CYC = `PPDC_RECOVER_CYC;
    localparam [`PPDC_CNT_W-1:0] CNT_ONE     = `PPDC_CNT_ONE;
    localparam [`PPDC_CNT_W-1:0] CNT_ZERO    = `PPDC_CNT_ZERO;
    localparam [DATA_W-1:0]      WORD_ZERO   = {DATA_W{1'h0}};

    reg  [1:0]             state_r;
    reg  [1:0]             state_nxt;
    reg  [`PPDC_CNT_W-1:0] cnt_r;
    reg  [`PPDC_CNT_W-1:0] cnt_nxt;
    wire                   req_a;
    wire                   req_b;
    wire                   pd_req;
    wire                   frozen;
    wire                   run_nxt;
    wire                   down_nxt;
    wire                   gp_a_nxt;
    wire                   gp_b_nxt;
    wire [DATA_W-1:0]      pin_in_nxt;
    wire [DATA_W-1:0]      pin_out_nxt;
    wire [DATA_W-1:0]      pin_oe_nxt;

    // A pin asks for power-down only while its feature is selected.
    // An unselected pin is an ordinary input and means nothing to the sequencer.
    function pin_request;
        input en;
        input level;
        begin
            pin_request = en & level;
        end
    endfunction

    // A selected pin is cut from the array, so its general path reads low.
    function gp_path;
        input en;
        input level;
        begin
            gp_path = en ? 1'h0 : level;
        end
    endfunction

    // The array may step only when the next state runs and no pin asks to stop.
    function run_after;
        input [1:0] st;
        input       req;
        begin
            run_after = (st == ST_RUN) & ~req;
        end
    endfunction

    // A frozen word keeps its last value; a running one follows its source.
    // One helper for the input, output and enable words keeps them all frozen on exactly the same edge.
    function [DATA_W-1:0] hold_word;
        input              hold;
        input [DATA_W-1:0] kept;
        input [DATA_W-1:0] fresh;
        begin
            hold_word = hold ? kept : fresh;
        end
    endfunction

    assign req_a    = pin_request(i_pd_en_a, i_power_down_pin_a);
    assign req_b    = pin_request(i_pd_en_b, i_power_down_pin_b);
    assign pd_req   = req_a | req_b;
    assign gp_a_nxt = gp_path(i_pd_en_a, i_power_down_pin_a);
    assign gp_b_nxt = gp_path(i_pd_en_b, i_power_down_pin_b);

    always @* begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            ST_RUN: begin
                if (pd_req) begin
                    state_nxt = ST_DOWN;
                end
            end
            ST_DOWN: begin
                if (!pd_req) begin
                    state_nxt = ST_RECOVER;
                    cnt_nxt   = RECOVER_CYC - CNT_ONE;
                end
            end
            ST_RECOVER: begin
                // A new request aborts recovery; the count restarts on the next release.
                if (pd_req) begin
                    state_nxt = ST_DOWN;
                end else if (cnt_r == CNT_ZERO) begin
                    state_nxt = ST_RUN;
                end else begin
                    cnt_nxt = cnt_r - CNT_ONE;
                end
            end
            default: begin
                state_nxt = ST_RUN;
                cnt_nxt   = CNT_ZERO;
            end
        endcase
    end

    // Recovery counts as frozen too: pins are trusted again only once it ends,
    // which costs at least 1 us of latency but never shows a half-woken value.
    assign frozen      = pd_req | (state_r != ST_RUN);
    assign run_nxt     = run_after(state_nxt, pd_req);
    assign down_nxt    = pd_req | (state_nxt == ST_DOWN);
    assign pin_in_nxt  = hold_word(frozen, o_pin_in_held, i_pin_in);
    assign pin_out_nxt = hold_word(frozen, o_pin_out, i_out_data);
    assign pin_oe_nxt  = hold_word(frozen, o_pin_oe, i_out_oe);

    always @(posedge i_clk) begin
        if (i_srst) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // The counter is loaded on release and read only during recovery.
    always @(posedge i_clk) begin
        if (i_srst) begin
            cnt_r <= CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            o_power_down <= 1'h0;
        end else begin
            o_power_down <= down_nxt;
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            o_valid <= 1'h1;
        end else begin
            o_valid <= run_nxt;
        end
    end

    // Nothing is cleared on release: the array resumes from what it held.
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_logic_run <= 1'h1;
        end else begin
            o_logic_run <= run_nxt;
        end
    end

    // The held input copy is the hold latch: while frozen the array sees the last
    // level taken, so a floating or changing pin cannot disturb internal state.
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_pin_in_held <= WORD_ZERO;
        end else begin
            o_pin_in_held <= pin_in_nxt;
        end
    end

    // Buried macrocell logic keeps its output path even when its pin is selected
    // for power-down; only the pin's input path is taken away.
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_pin_out <= WORD_ZERO;
        end else begin
            o_pin_out <= pin_out_nxt;
        end
    end

    // A held enable of zero keeps a high-impedance output off for the whole period.
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_pin_oe <= WORD_ZERO;
        end else begin
            o_pin_oe <= pin_oe_nxt;
        end
    end

    // The general input paths freeze with everything else.
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_gp_a <= 1'h0;
        end else if (!frozen) begin
            o_gp_a <= gp_a_nxt;
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            o_gp_b <= 1'h0;
        end else if (!frozen) begin
            o_gp_b <= gp_b_nxt;
        end
    end

endmodule // ppdc_power_down

// file: dv/ppdc_pd_host.sv
`timescale 1ns/100ps
module ppdc_pd_host (
    input  wire logic i_clk,
    input  wire logic i_req_a,
    input  wire logic i_req_b,
    output logic      o_pin_a,
    output logic      o_pin_b
);
    // Pins move just after an edge, as a board driver would.
    always @(posedge i_clk) {o_pin_a, o_pin_b} <= #1 {i_req_a, i_req_b};
endmodule // ppdc_pd_host

// file: dv/ppdc_power_down_properties.sv
`timescale 1ns/100ps
module ppdc_power_down_properties #(parameter DATA_W = 8) (
    input wire i_clk, i_srst, i_pd_en_a, i_pd_en_b, i_power_down_pin_a,
    input wire [DATA_W-1:0] i_pin_in, o_pin_in_held, o_pin_out, o_pin_oe,
    input wire o_gp_a, o_logic_run, o_power_down, o_valid
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_pd_enter: assert property (i_pd_en_a && i_power_down_pin_a |=> o_power_down && !o_valid) else $error("enter");
    a_pd_disabled: assert property (!i_pd_en_a && !i_pd_en_b |=> !o_power_down) else $error("disabled");
    a_out_held: assert property (o_power_down |-> $stable(o_pin_out)) else $error("out moved");
    a_oe_held: assert property (!o_valid |=> $stable(o_pin_oe)) else $error("oe moved");
    a_in_blocked: assert property (!o_valid |=> $stable(o_pin_in_held)) else $error("in moved");
    a_gp_blocked: assert property (o_valid && $past(o_valid) && $past(i_pd_en_a) |-> !o_gp_a) else $error("gp");
    a_recover_time: assert property ($fell(o_power_down) |-> ##[1:40] (o_valid || o_power_down)) else $error("slow");
    a_run_match: assert property (o_logic_run == o_valid && !(o_power_down && o_valid)) else $error("flags");
    a_resume_data: assert property ($rose(o_valid) ##1 o_valid |-> o_pin_in_held == $past(i_pin_in)) else $error("resume");
endmodule // ppdc_power_down_properties
bind ppdc_power_down ppdc_power_down_properties #(.DATA_W(DATA_W)) u_props (.*);

// file: dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic i_clk = 0, i_srst = 1, i_pd_en_a = 0, i_pd_en_b = 0, ra = 0, rb = 0;
    logic i_power_down_pin_a, i_power_down_pin_b, o_gp_a, o_gp_b, o_logic_run, o_power_down, o_valid;
    logic [7:0] i_pin_in = 8'h00, i_out_data = 8'h00, i_out_oe = 8'h00, o_pin_in_held, o_pin_out, o_pin_oe;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    logic [4:0] rows [4] = '{5'b10101, 5'b01011, 5'b00100, 5'b10010};
    always #12.5 i_clk = ~i_clk;
    ppdc_pd_host u_host (.i_clk, .i_req_a(ra), .i_req_b(rb), .o_pin_a(i_power_down_pin_a), .o_pin_b(i_power_down_pin_b));
    ppdc_power_down uut (.*);
    task step(int n); repeat (n) @(posedge i_clk); #1; endtask
    task chk(string s, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin n_mismatch++; $display("mismatch %s exp %h got %h", s, e, g); end
    endtask
    task summarize;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // The whole run needs about 310 cycles.
    always @(posedge i_clk) if (++cyc == 3000) begin n_mismatch++; summarize(); end
    initial begin
        step(8);
        i_srst = 0;
        foreach (rows[i]) begin
            {i_pd_en_a, i_pd_en_b, ra, rb} = rows[i][4:1];
            step(3);
            chk("freeze", rows[i][0], o_power_down);
            chk("run", !rows[i][0], o_logic_run);
            chk("valid_dn", !rows[i][0], o_valid);
            chk("gp_a", !i_pd_en_a & ra, o_gp_a);
            chk("gp_b", !i_pd_en_b & rb, o_gp_b);
            {ra, rb} = 0;
            step(44);
            chk("valid", 1, o_valid);
        end
        {i_pin_in, i_out_data, i_out_oe, i_pd_en_a} = {24'h5A3C0F, 1'b1};
        step(2);
        ra = 1;
        step(3);
        {i_pin_in, i_out_data, i_out_oe} = 24'hA5C3F0;
        step(20);
        chk("held", 8'h5A, o_pin_in_held);
        chk("out", 8'h3C, o_pin_out);
        chk("oe", 8'h0F, o_pin_oe);
        ra = 0;
        step(44);
        chk("resume", 8'hA5, o_pin_in_held);
        chk("out_new", 8'hC3, o_pin_out);
        chk("oe_new", 8'hF0, o_pin_oe);
        // A second reset in mid-run, then power-down straight after it.
        i_srst = 1;
        step(2);
        chk("rst_in", 8'h00, o_pin_in_held);
        chk("rst_pd", 0, o_power_down);
        i_srst = 0;
        ra = 1;
        step(3);
        chk("rst_freeze", 1, o_power_down);
        chk("rst_keep", 8'hA5, o_pin_in_held);
        ra = 0;
        step(44);
        chk("rst_valid", 1, o_valid);
        summarize();
    end
endmodule // tb_top
